//--- src/owdc_defines.svh
`ifndef OWDC_DEFINES_SVH
`define OWDC_DEFINES_SVH

// system clock rate
`define OWDC_CLK_MHZ 20
// frame layout
`define OWDC_FRAME_BITS 24
`define OWDC_ADDR_MSB 23
`define OWDC_ADDR_LSB 16
`define OWDC_DEV_ADDR 8'h8f
`define OWDC_ACK_BIT 10
`define OWDC_BRT_MSB 8
`define OWDC_BRT_LSB 1
`define OWDC_BRT_RESET 8'hff
`define OWDC_CMD_RESET 16'h0000
// switch-node overvoltage persistence, in switching cycles
`define OWDC_OVP_CYCLES 4'h8
// times in microseconds, as printed
`define OWDC_TW0_US 100
`define OWDC_TW1_US 260
`define OWDC_TSEL_US 1000
`define OWDC_TOFFEN_US 2500
`define OWDC_TOFFPWM_US 20000
`define OWDC_TSTART_US 2
`define OWDC_TEND_US 2
`define OWDC_THMAX_US 360
`define OWDC_TACKD_US 2
`define OWDC_TACK_US 512
// derived cycle counts (all times are whole microseconds, so exact)
`define OWDC_TW0_CYC (`OWDC_TW0_US * `OWDC_CLK_MHZ)
`define OWDC_TW1_CYC (`OWDC_TW1_US * `OWDC_CLK_MHZ)
`define OWDC_TSEL_CYC (`OWDC_TSEL_US * `OWDC_CLK_MHZ)
`define OWDC_TOFFEN_CYC (`OWDC_TOFFEN_US * `OWDC_CLK_MHZ)
`define OWDC_TOFFPWM_CYC (`OWDC_TOFFPWM_US * `OWDC_CLK_MHZ)
`define OWDC_TSTART_CYC (`OWDC_TSTART_US * `OWDC_CLK_MHZ)
`define OWDC_TEND_CYC (`OWDC_TEND_US * `OWDC_CLK_MHZ)
`define OWDC_THMAX_CYC (`OWDC_THMAX_US * `OWDC_CLK_MHZ)
`define OWDC_TACKD_CYC (`OWDC_TACKD_US * `OWDC_CLK_MHZ)
`define OWDC_TACK_CYC (`OWDC_TACK_US * `OWDC_CLK_MHZ)

`endif

//--- src/owdc_pkg.sv
package owdc_pkg;

   // control states
   typedef enum logic [2:0]
   {
      OWDC_OFF = 3'b000,
      OWDC_SEL_HIGH = 3'b001,
      OWDC_SEL_LOW = 3'b010,
      OWDC_PWM = 3'b011,
      OWDC_DIG = 3'b100,
      OWDC_ACK_DLY = 3'b101,
      OWDC_ACK_DRV = 3'b110
   } owdc_state_t;

   // bit receiver state
   typedef struct packed
   {
      logic line_prev;
      logic [15:0] hi_cnt;
      logic [15:0] lo_cnt;
      logic stb;
      logic val;
      logic tail_ok;
   } owdc_rx_t;

   // control state
   typedef struct packed
   {
      owdc_state_t st;
      logic en_prev;
      logic [18:0] sel_cnt;
      logic [18:0] ph_cnt;
      logic [18:0] en_lo_cnt;
      logic [18:0] pwm_lo_cnt;
      logic [23:0] shift;
      logic [4:0] bit_cnt;
      logic [7:0] bright;
      logic [15:0] cmd_word;
      logic [3:0] ovp_cnt;
      logic ocp_hold;
      logic drive_on;
      logic sw_permit;
      logic ack_oe;
      logic [7:0] sink_one;
      logic [7:0] sink_two;
   } owdc_ctl_t;

endpackage

//--- src/owdc_bit_rx.sv
`timescale 1ns/1ps
`include "owdc_defines.svh"

module owdc_bit_rx
   import owdc_pkg::*;
#(
   parameter int THMAX_CYC = `OWDC_THMAX_CYC
)
(
   input wire logic clk_sys,  // system clock
   input wire logic nrst,  // async reset, active low
   input wire logic rx_en,  // decoding allowed
   input wire logic line_in,  // single-wire line level
   output logic bit_stb,  // one-cycle pulse, bit decoded
   output logic bit_val,  // decoded bit value
   output logic tail_ok,  // low part of that bit met the end time
   output logic line_idle  // line high past longest bit high time
);

   localparam logic [15:0] TSTART_L = 16'(`OWDC_TSTART_CYC);
   localparam logic [15:0] TEND_L = 16'(`OWDC_TEND_CYC);
   localparam logic [15:0] THMAX_L = 16'(THMAX_CYC);

   owdc_rx_t q;
   owdc_rx_t d;

   ////////////////////////////////////////////////////////////////////////
   // measure high and low parts, decode at the closing rising edge
   always_comb
   begin
      d = q;
      d.stb = 1'b0;
      d.line_prev = line_in;
      if (!rx_en)
      begin
         d.hi_cnt = 16'h0000;
         d.lo_cnt = 16'h0000;
      end
      else if (line_in && !q.line_prev)
      begin
         if (q.hi_cnt >= TSTART_L && q.lo_cnt != 16'h0000)
         begin
            d.stb = 1'b1;
            d.val = (q.hi_cnt > q.lo_cnt);
            d.tail_ok = (q.lo_cnt >= TEND_L);
         end
         d.hi_cnt = 16'h0001;
         d.lo_cnt = 16'h0000;
      end
      else if (line_in)
      begin
         if (q.hi_cnt != 16'hffff)
            d.hi_cnt = q.hi_cnt + 16'h0001;
      end
      else if (q.lo_cnt != 16'hffff)
      begin
         d.lo_cnt = q.lo_cnt + 16'h0001;
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         q <= '{line_prev: 1'b1, hi_cnt: 16'h0000, lo_cnt: 16'h0000, stb: 1'b0, val: 1'b0, tail_ok: 1'b0};
      else
         q <= d;
   end

   assign bit_stb = q.stb;
   assign bit_val = q.val;
   assign tail_ok = q.tail_ok;
   assign line_idle = (q.hi_cnt >= THMAX_L);

endmodule

//--- src/owdc_ctrl.sv
`timescale 1ns/1ps
`include "owdc_defines.svh"


module owdc_ctrl
   import owdc_pkg::*;
#(
   parameter int TW1_CYC = `OWDC_TW1_CYC,
   parameter int TSEL_CYC = `OWDC_TSEL_CYC,
   parameter int TOFFEN_CYC = `OWDC_TOFFEN_CYC,
   parameter int TOFFPWM_CYC = `OWDC_TOFFPWM_CYC,
   parameter int TACK_CYC = `OWDC_TACK_CYC,
   parameter int THMAX_CYC = `OWDC_THMAX_CYC
)
(
   input wire logic clk_sys,  // system clock, 20 MHz
   input wire logic nrst,  // async reset, active low
   input wire logic single_wire_in,  // single-wire line level
   output logic single_wire_out,  // line drive value, always low
   output logic single_wire_oe,  // high while pulling line low
   input wire logic pwm_in,  // PWM dimming input
   input wire logic sw_ovp_det,  // switch-node overvoltage
   input wire logic sink_ovp_one,  // sink one overvoltage
   input wire logic sink_ovp_two,  // sink two overvoltage
   input wire logic sink_gnd_one,  // sink one tied to ground
   input wire logic sink_gnd_two,  // sink two tied to ground
   input wire logic peak_over_limit,  // switch peak current over limit
   input wire logic sw_cycle_tick,  // pulse at each switching cycle start
   input wire logic uvlo_det,  // supply undervoltage
   output logic device_on,  // device enabled
   output logic digital_mode,  // single-wire dimming selected
   output logic switch_permit,  // converter may switch
   output logic [7:0] sink_code_one,  // sink one current code
   output logic [7:0] sink_code_two,  // sink two current code
   output logic [7:0] brightness_code,  // stored brightness code
   output logic [15:0] dimming_command_word  // last accepted data field
);

   localparam logic [18:0] TW0_L = 19'(`OWDC_TW0_CYC);
   localparam logic [18:0] TW1_L = 19'(TW1_CYC);
   localparam logic [18:0] TSEL_L = 19'(TSEL_CYC);
   localparam logic [18:0] TOFFEN_L = 19'(TOFFEN_CYC);
   localparam logic [18:0] TOFFPWM_L = 19'(TOFFPWM_CYC);
   localparam logic [18:0] TACKD_L = 19'(`OWDC_TACKD_CYC);
   localparam logic [18:0] TACK_L = 19'(TACK_CYC);
   localparam logic [4:0] LAST_BIT = 5'(`OWDC_FRAME_BITS - 1);

   owdc_ctl_t q;
   owdc_ctl_t d;

   logic bit_stb;
   logic bit_val;
   logic tail_ok;
   logic line_idle;
   logic rx_en;
   logic [23:0] frame;
   logic active;
   logic in_ack;
   logic shutdown;

   ////////////////////////////////////////////////////////////////////////
   // bit receiver, only listening in digital mode outside acknowledge
   assign rx_en = (q.st == OWDC_DIG);

   owdc_bit_rx #(
      .THMAX_CYC(THMAX_CYC)
   ) u_bit_rx (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .rx_en(rx_en),
      .line_in(single_wire_in),
      .bit_stb(bit_stb),
      .bit_val(bit_val),
      .tail_ok(tail_ok),
      .line_idle(line_idle)
   );

   // lsb first, shift toward bit 0
   assign frame = {bit_val, q.shift[23:1]};
   assign in_ack = (q.st == OWDC_ACK_DLY) || (q.st == OWDC_ACK_DRV);
   assign active = (q.st == OWDC_PWM) || (q.st == OWDC_DIG) || in_ack;

   ////////////////////////////////////////////////////////////////////////
   // shutdown causes
   always_comb
   begin
      shutdown = 1'b0;
      if (uvlo_det)
         shutdown = 1'b1;
      if (q.st != OWDC_OFF && !in_ack && q.en_lo_cnt >= TOFFEN_L)
         shutdown = 1'b1;
      if (active && q.pwm_lo_cnt >= TOFFPWM_L)
         shutdown = 1'b1;
      if (active && sw_cycle_tick && sw_ovp_det && q.ovp_cnt == `OWDC_OVP_CYCLES - 4'h1)
         shutdown = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      d = q;
      d.en_prev = single_wire_in;
      d.ack_oe = 1'b0;

      // low-time counters
      if (single_wire_in || q.st == OWDC_OFF || in_ack)
         d.en_lo_cnt = 19'h00000;
      else if (q.en_lo_cnt != 19'h7ffff)
         d.en_lo_cnt = q.en_lo_cnt + 19'h00001;
      if (pwm_in || !active)
         d.pwm_lo_cnt = 19'h00000;
      else if (q.pwm_lo_cnt != 19'h7ffff)
         d.pwm_lo_cnt = q.pwm_lo_cnt + 19'h00001;

      // overvoltage cycle count, cleared when a cycle passes clean
      if (!active)
         d.ovp_cnt = 4'h0;
      else if (sw_cycle_tick)
         d.ovp_cnt = sw_ovp_det ? q.ovp_cnt + 4'h1 : 4'h0;

      // switch off until next cycle, a new trip wins over the clear
      if (peak_over_limit)
         d.ocp_hold = 1'b1;
      else if (sw_cycle_tick)
         d.ocp_hold = 1'b0;

      unique case (q.st)
         OWDC_OFF:
         begin
            // only a fresh rising edge restarts
            if (single_wire_in && !q.en_prev && !uvlo_det)
            begin
               d.st = OWDC_SEL_HIGH;
               d.sel_cnt = 19'h00000;
               d.ph_cnt = 19'h00000;
            end
         end
         OWDC_SEL_HIGH:
         begin
            d.sel_cnt = q.sel_cnt + 19'h00001;
            d.ph_cnt = q.ph_cnt + 19'h00001;
            if (!single_wire_in)
            begin
               d.st = (q.ph_cnt >= TW0_L) ? OWDC_SEL_LOW : OWDC_PWM;
               d.ph_cnt = 19'h00000;
            end
            else if (q.sel_cnt >= TSEL_L)
               d.st = OWDC_PWM;
         end
         OWDC_SEL_LOW:
         begin
            d.sel_cnt = q.sel_cnt + 19'h00001;
            d.ph_cnt = q.ph_cnt + 19'h00001;
            // entry low time completes digital entry
            if (q.ph_cnt >= TW1_L)
            begin
               d.st = OWDC_DIG;
               d.bit_cnt = 5'h00;
            end
            else if (single_wire_in || q.sel_cnt >= TSEL_L)
               d.st = OWDC_PWM;
         end
         OWDC_PWM:
         begin
            // stays here, pwm input gates the outputs
            d.st = OWDC_PWM;
         end
         OWDC_DIG:
         begin
            // idle high drops a partial frame
            if (line_idle)
               d.bit_cnt = 5'h00;
            if (bit_stb)
            begin
               d.shift = frame;
               d.bit_cnt = q.bit_cnt + 5'h01;
               if (q.bit_cnt == LAST_BIT)
               begin
                  d.bit_cnt = 5'h00;
                  if (tail_ok && frame[`OWDC_ADDR_MSB:`OWDC_ADDR_LSB] == `OWDC_DEV_ADDR)
                  begin
                     d.cmd_word = frame[15:0];
                     if (frame[`OWDC_BRT_MSB:`OWDC_BRT_LSB] != 8'h00)
                        d.bright = frame[`OWDC_BRT_MSB:`OWDC_BRT_LSB];
                     if (frame[`OWDC_ACK_BIT])
                     begin
                        d.st = OWDC_ACK_DLY;
                        d.ph_cnt = 19'h00000;
                     end
                  end
               end
            end
         end
         OWDC_ACK_DLY:
         begin
            // give the host time to release
            d.ph_cnt = q.ph_cnt + 19'h00001;
            if (q.ph_cnt >= TACKD_L - 19'h00001)
            begin
               d.st = OWDC_ACK_DRV;
               d.ph_cnt = 19'h00000;
               d.ack_oe = 1'b1;
            end
         end
         OWDC_ACK_DRV:
         begin
            d.ph_cnt = q.ph_cnt + 19'h00001;
            d.ack_oe = 1'b1;
            if (q.ph_cnt >= TACK_L - 19'h00001)
            begin
               d.st = OWDC_DIG;
               d.ack_oe = 1'b0;
            end
         end
         default:
         begin
            d.st = OWDC_OFF;
         end
      endcase

      if (shutdown)
      begin
         d.st = OWDC_OFF;
         d.ack_oe = 1'b0;
         d.bit_cnt = 5'h00;
         d.bright = `OWDC_BRT_RESET;
         d.cmd_word = `OWDC_CMD_RESET;
      end

      // enabled with line and pwm high, own acknowledge excused
      d.drive_on = (d.st == OWDC_PWM || d.st == OWDC_DIG || d.st == OWDC_ACK_DLY || d.st == OWDC_ACK_DRV)
         && pwm_in && (single_wire_in || d.st == OWDC_ACK_DLY || d.st == OWDC_ACK_DRV);

      d.sw_permit = d.drive_on && !sw_ovp_det && !sink_ovp_one && !sink_ovp_two
         && !(sink_gnd_one && sink_gnd_two) && !d.ocp_hold;

      // a grounded sink is switched off
      d.sink_one = (d.drive_on && !sink_gnd_one) ? d.bright : 8'h00;
      d.sink_two = (d.drive_on && !sink_gnd_two) ? d.bright : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register, reset is the shutdown state
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         q <= '0;
         q.st <= OWDC_OFF;
         q.en_prev <= 1'b1;
         q.bright <= `OWDC_BRT_RESET;
         q.cmd_word <= `OWDC_CMD_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   // outputs
   assign single_wire_out = 1'b0;
   assign single_wire_oe = q.ack_oe;
   assign device_on = q.drive_on;
   assign digital_mode = (q.st == OWDC_DIG) || in_ack;
   assign switch_permit = q.sw_permit;
   assign sink_code_one = q.sink_one;
   assign sink_code_two = q.sink_two;
   assign brightness_code = q.bright;
   assign dimming_command_word = q.cmd_word;

endmodule

//--- bench/owdc_ctrl_monitor.sv
`timescale 1ns/1ps

module owdc_ctrl_monitor
#(
   parameter int TACK_CYC = 10240
)
(
   input wire logic clk_sys,  // clock
   input wire logic nrst,  // reset, active low
   input wire logic single_wire_oe,  // line pull enable
   input wire logic digital_mode,  // mode
   input wire logic device_on,  // enabled
   input wire logic switch_permit,  // converter may switch
   input wire logic sw_ovp_det,  // switch-node ovp
   input wire logic sink_ovp_one,  // sink ovp
   input wire logic sink_ovp_two,  // sink ovp
   input wire logic sink_gnd_one,  // sink grounded
   input wire logic sink_gnd_two,  // sink grounded
   input wire logic peak_over_limit,  // peak current
   input wire logic uvlo_det,  // undervoltage
   input wire logic [7:0] sink_code_one,  // sink code
   input wire logic [7:0] sink_code_two  // sink code
);
   logic [15:0] oe_cnt_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // counts cycles of the acknowledge pull
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         oe_cnt_q <= 16'h0000;
      else
         oe_cnt_q <= single_wire_oe ? oe_cnt_q + 16'h0001 : 16'h0000;
   end

   a_ack_length: assert property ($fell(single_wire_oe) |-> oe_cnt_q == TACK_CYC)
      else $error("acknowledge pull has wrong length");
   a_ack_in_dig: assert property (single_wire_oe |-> digital_mode)
      else $error("line pulled outside digital mode");
   a_swovp_stop: assert property (sw_ovp_det |=> !switch_permit)
      else $error("switching during switch-node overvoltage");
   a_sinkovp_stop: assert property ((sink_ovp_one || sink_ovp_two) |=> !switch_permit)
      else $error("switching during sink overvoltage");
   a_both_gnd: assert property (sink_gnd_one && sink_gnd_two |=> !switch_permit)
      else $error("switching with both sinks grounded");
   a_peak_stop: assert property (peak_over_limit |=> !switch_permit)
      else $error("switching after peak current over limit");
   a_permit_on: assert property (switch_permit |-> device_on || $past(device_on))
      else $error("switching while device disabled");
   a_uvlo_off: assert property (uvlo_det |-> ##2 !device_on)
      else $error("device on during undervoltage");
   a_sinks_equal: assert property (!sink_gnd_one && !sink_gnd_two && !$past(sink_gnd_one)
      && !$past(sink_gnd_two) |-> sink_code_one == sink_code_two)
      else $error("sink codes differ");

   c_ack: cover property ($rose(single_wire_oe));
   c_dig: cover property ($rose(digital_mode));
   c_off: cover property ($fell(device_on));
endmodule

bind owdc_ctrl owdc_ctrl_monitor #(.TACK_CYC(TACK_CYC)) owdc_ctrl_monitor_inst
(
   .clk_sys(clk_sys),
   .nrst(nrst),
   .single_wire_oe(single_wire_oe),
   .digital_mode(digital_mode),
   .device_on(device_on),
   .switch_permit(switch_permit),
   .sw_ovp_det(sw_ovp_det),
   .sink_ovp_one(sink_ovp_one),
   .sink_ovp_two(sink_ovp_two),
   .sink_gnd_one(sink_gnd_one),
   .sink_gnd_two(sink_gnd_two),
   .peak_over_limit(peak_over_limit),
   .uvlo_det(uvlo_det),
   .sink_code_one(sink_code_one),
   .sink_code_two(sink_code_two)
);

//--- bench/owdc_host_model.sv
`timescale 1ns/1ps

module owdc_host_model
#(
   parameter int TW1_CYC = 5200,
   parameter int TSEL_CYC = 20000
)
(
   input wire logic clk_sys,  // clock
   input wire logic single_wire_oe,  // device pull enable
   input wire logic single_wire_out,  // device drive value
   output logic line_lvl  // resolved line level
);
   logic drv_low = 1'b0;

   assign line_lvl = !(drv_low || (single_wire_oe && !single_wire_out));

   // holds the line at a level for n cycles
   task automatic hold(input logic lvl, input int n);
      drv_low <= !lvl;
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic enter_dig();
      hold(1'b0, 4);
      hold(1'b1, 2010);
      hold(1'b0, TW1_CYC + 4);
      hold(1'b1, 10);
   endtask

   // no entry pattern, line stays high
   task automatic enter_pwm();
      hold(1'b0, 4);
      hold(1'b1, TSEL_CYC + 10);
   endtask

   function automatic logic [23:0] frm(input logic ack, input logic [7:0] code, input logic [7:0] addr);
      return {addr, 5'h00, ack, 1'b0, code, 1'b1};
   endfunction

   // whole frame, lsb first, idle high
   task automatic send_frame(input logic [23:0] f);
      for (int i = 0; i < 24; i++)
      begin
         hold(1'b1, f[i] ? 80 : 40);
         hold(1'b0, f[i] ? 40 : 80);
      end
      hold(1'b1, 1);
   endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps

module tb;
   import owdc_pkg::*;
   localparam int TW1 = 52;
   localparam int TSEL = 2200;
   localparam int TOFFEN = 500;
   localparam int TOFFPWM = 4000;
   localparam int TACK = 100;
   logic clk_sys, nrst, line, pwm_in, sw_ovp_det, sink_ovp_one, sink_ovp_two;
   logic sink_gnd_one, sink_gnd_two, peak_over_limit, sw_cycle_tick, uvlo_det;
   logic single_wire_out, single_wire_oe, device_on, digital_mode, switch_permit, ack_seen;
   logic [7:0] sink_code_one, sink_code_two, brightness_code;
   logic [15:0] dimming_command_word;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   owdc_ctrl #(.TW1_CYC(TW1), .TSEL_CYC(TSEL), .TOFFEN_CYC(TOFFEN), .TOFFPWM_CYC(TOFFPWM),
      .TACK_CYC(TACK), .THMAX_CYC(300)) owdc_ctrl_inst
   (
      .clk_sys(clk_sys), .nrst(nrst), .single_wire_in(line), .single_wire_out(single_wire_out),
      .single_wire_oe(single_wire_oe), .pwm_in(pwm_in), .sw_ovp_det(sw_ovp_det),
      .sink_ovp_one(sink_ovp_one), .sink_ovp_two(sink_ovp_two), .sink_gnd_one(sink_gnd_one),
      .sink_gnd_two(sink_gnd_two), .peak_over_limit(peak_over_limit), .sw_cycle_tick(sw_cycle_tick),
      .uvlo_det(uvlo_det), .device_on(device_on), .digital_mode(digital_mode),
      .switch_permit(switch_permit), .sink_code_one(sink_code_one), .sink_code_two(sink_code_two),
      .brightness_code(brightness_code), .dimming_command_word(dimming_command_word)
   );

   owdc_host_model #(.TW1_CYC(TW1), .TSEL_CYC(TSEL)) owdc_host_model_inst
   (
      .clk_sys(clk_sys), .single_wire_oe(single_wire_oe), .single_wire_out(single_wire_out),
      .line_lvl(line)
   );

   // clock and run-length guard
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = !clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fail_count++;
         tally_and_finish();
      end
      if (single_wire_oe === 1'b1 && line === 1'b0)
         ack_seen <= 1'b1;
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic frame(input logic ack, input logic [7:0] code, input logic [7:0] addr);
      ack_seen <= 1'b0;
      owdc_host_model_inst.send_frame(owdc_host_model_inst.frm(ack, code, addr));
      repeat (TACK + 60) @(posedge clk_sys);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // main sequence
   initial
   begin
      {nrst, sw_ovp_det, sink_ovp_one, sink_ovp_two, sink_gnd_one, sink_gnd_two} = 6'h00;
      {peak_over_limit, sw_cycle_tick, uvlo_det, ack_seen} = 4'h0;
      pwm_in = 1'b1;
      wt(5);
      nrst <= 1'b1;
      wt(1);
      chk(brightness_code, 8'hff);
      chk(dimming_command_word, 16'h0000);
      owdc_host_model_inst.enter_pwm();
      chk(digital_mode, 1'b0);
      chk(device_on, 1'b1);
      pwm_in <= 1'b0;
      wt(5);
      chk(device_on, 1'b0);
      pwm_in <= 1'b1;
      wt(5);
      chk(device_on, 1'b1);
      pwm_in <= 1'b0;
      wt(TOFFPWM + 10);
      pwm_in <= 1'b1;
      wt(5);
      chk(device_on, 1'b0);
      $display("pwm mode test done");
      owdc_host_model_inst.enter_dig();
      chk(digital_mode, 1'b1);
      frame(1'b1, 8'h5a, 8'h8f);
      chk(brightness_code, 8'h5a);
      chk(sink_code_one, 8'h5a);
      chk(sink_code_two, 8'h5a);
      chk(dimming_command_word[15:1], {5'h00, 1'b1, 1'b0, 8'h5a});
      chk(ack_seen, 1'b1);
      frame(1'b0, 8'h01, 8'h8f);
      chk(brightness_code, 8'h01);
      chk(ack_seen, 1'b0);
      frame(1'b1, 8'h33, 8'h8e);
      chk(brightness_code, 8'h01);
      chk(ack_seen, 1'b0);
      frame(1'b0, 8'h00, 8'h8f);
      chk(brightness_code, 8'h01);
      $display("frame test done");
      sink_ovp_one <= 1'b1;
      wt(3);
      chk({switch_permit, sink_code_one}, 9'h001);
      sink_ovp_one <= 1'b0;
      sink_gnd_one <= 1'b1;
      wt(3);
      chk({switch_permit, sink_code_one}, 9'h100);
      sink_gnd_two <= 1'b1;
      wt(3);
      chk(switch_permit, 1'b0);
      {sink_gnd_one, sink_gnd_two, peak_over_limit} <= 3'h1;
      wt(1);
      peak_over_limit <= 1'b0;
      wt(3);
      chk(switch_permit, 1'b0);
      sw_cycle_tick <= 1'b1;
      wt(1);
      sw_cycle_tick <= 1'b0;
      wt(3);
      chk(switch_permit, 1'b1);
      sw_ovp_det <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         sw_cycle_tick <= 1'b1;
         wt(1);
         sw_cycle_tick <= 1'b0;
         wt(3);
         if (i == 6)
            chk({switch_permit, device_on}, 2'h1);
      end
      sw_ovp_det <= 1'b0;
      chk({device_on, brightness_code}, 9'h0ff);
      $display("protection test done");
      owdc_host_model_inst.enter_dig();
      frame(1'b0, 8'h80, 8'h8f);
      chk({device_on, brightness_code}, 9'h180);
      owdc_host_model_inst.hold(1'b0, TOFFEN + 10);
      chk(device_on, 1'b0);
      owdc_host_model_inst.enter_dig();
      chk(digital_mode, 1'b1);
      uvlo_det <= 1'b1;
      wt(3);
      chk({device_on, digital_mode}, 2'h0);
      $display("shutdown test done");
      tally_and_finish();
   end
endmodule
